// ==== hw/status_io_regs.svh ====
// Register offsets, reset values and sizes of the analyzer status and control block.
`ifndef STATUS_IO_REGS_SVH
`define STATUS_IO_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CONDITION_OFFSET 12'h000
`define PIN_STATE_OFFSET 12'h004
`define EVENT_OFFSET 12'h008
`define EVENT_MASK_OFFSET 12'h00C

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define CONDITION_WIDTH 12
`define CONDITION_RESET 12'h000
`define EVENT_COUNT 4
`define EVENT_RESET 4'h0
`define EVENT_MASK_RESET 4'h0
`define REMOTE_COUNT 2
`define SYNC_RESET 2'h0
`define READ_IDLE 32'h0000_0000

`endif

// ==== hw/status_io_pkg.sv ====
// Types shared by the analyzer status and control block.
package status_io_pkg;

    typedef enum logic [1:0] {
        RANGE_SINGLE,
        RANGE_DUAL,
        RANGE_AUTO
    } range_mode_type;

    typedef struct packed {
        logic conc2_above;
        logic conc1_above;
        logic warning_active;
        logic diag;
        logic span_cal_run;
        logic zero_cal_run;
        range_mode_type range_mode;
        logic in_high_range;
        logic hold_off;
        logic flow_fault;
        logic fault_present;
    } condition_type;

    typedef struct packed {
        logic spare_8;
        logic spare_7;
        logic service_mode_active;
        logic span_cal;
        logic zero_cal;
        logic high_range;
        logic conc_valid;
        logic system_ok;
    } status_pins_type;

    typedef struct packed {
        logic range_relay;
        logic conc2_relay;
        logic conc1_relay;
        logic health_relay;
    } relay_type;

    typedef struct packed {
        logic conc2_rise;
        logic conc1_rise;
        logic remote_span_rise;
        logic remote_zero_rise;
    } event_type;

    typedef enum {
        SELECT_CONDITION,
        SELECT_PIN_STATE,
        SELECT_EVENT,
        SELECT_EVENT_MASK,
        SELECT_NONE
    } register_select_type;

endpackage

// ==== hw/input_sync.sv ====
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`include "status_io_regs.svh"

module input_sync #(
    parameter int WIDTH = `REMOTE_COUNT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    generate
        if (WIDTH < 1) begin : width_check
            $error("Synchroniser width must be at least one.");
        end
    endgenerate

    always_comb begin
        next_state.first = pin;
        next_state.second = state.first;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.second;

endmodule

// ==== hw/event_flags.sv ====
// Sticky event flags with write-one-to-clear, a mask and one level interrupt.
`timescale 1ns/1ps
`include "status_io_regs.svh"

module event_flags #(
    parameter int WIDTH = `EVENT_COUNT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    input wire logic mask_write,
    input wire logic [WIDTH-1:0] mask_data,
    output logic [WIDTH-1:0] flags,
    output logic [WIDTH-1:0] mask,
    output logic interrupt
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
        logic [WIDTH-1:0] mask;
    } flag_state_type;

    flag_state_type state;
    flag_state_type next_state;

    generate
        if (WIDTH < 1) begin : width_check
            $error("Event width must be at least one.");
        end
    endgenerate

    // A set in the cycle of a clear wins, so no event is lost.
    always_comb begin
        next_state = state;
        next_state.flags = (state.flags & ~clear) | set;
        if (mask_write) begin
            next_state.mask = mask_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags = state.flags;
    assign mask = state.mask;
    assign interrupt = |(state.flags & state.mask);

endmodule

// ==== hw/analyzer_status_control_io.sv ====
// Status outputs, remote calibration inputs and alarm relay drive of a gas analyzer, with an APB register slave.
`timescale 1ns/1ps
`include "status_io_regs.svh"

//
// Summary of operation
// [RULE1] The system-ok status output is on while no fault is present and off while any fault exists; it tracks fault_present only, not flow_fault.
// [RULE2] The concentration-valid output is on only while the reading is valid, off during hold-off or a flow fault.
// [RULE3] The high-range output is on while the unit runs in the high range of dual or automatic range mode.
// [RULE4] The zero-calibration output is on during a zero calibration and the span-calibration output during a span one.
// [RULE5] The service-mode output is on for as long as the instrument stays in diagnostic mode.
// [RULE6] While the remote zero input is held on, the unit is in zero calibration and shows the remote-zero indication.
// [RULE7] While the remote span input is held on and the remote zero input is off, the unit is in low-span calibration and shows that indication.
// [RULE8] Four relays carry the health signal, the two concentration alarms and the range bit.
// [RULE9] The first relay is energized while the instrument is healthy and no warning is active.
// [RULE10] The first relay is de-energized whenever a warning is active or diagnostic mode is entered.
// [RULE11] The first relay uses inverted sense so that a dead or unpowered unit looks like a fault.
// [RULE12] The second relay follows the first concentration set point without latching.
// [RULE13] The concentration warning stays latched after the relay releases until software clears it.
// [RULE14] With automatic ranging configured, the fourth relay is on while the reading is in the high range.
// [RULE15] Spare status outputs stay off and spare control inputs are ignored.
module analyzer_status_control_io
    import status_io_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int SPARE_INPUTS = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic remote_zero_in,
    input wire logic remote_span_in,
    input wire logic [SPARE_INPUTS-1:0] spare_in,
    output status_pins_type status_pins,
    output relay_type relays,
    output logic remote_zero_indication,
    output logic remote_low_reference_indication,
    output logic conc_warning_latched,
    output logic interrupt
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        condition_type condition;
        logic [31:0] read_data;
        logic slave_error;
        status_pins_type pins;
        relay_type relays;
        logic zero_indication;
        logic span_indication;
        logic remote_zero_last;
        logic remote_span_last;
        logic conc1_last;
        logic conc2_last;
    } block_state_type;

    block_state_type state;
    block_state_type next_state;

    logic [`REMOTE_COUNT-1:0] remote_level;
    logic [`EVENT_COUNT-1:0] event_flags_now;
    logic [`EVENT_COUNT-1:0] event_mask_now;
    event_type event_set;
    logic [`EVENT_COUNT-1:0] event_clear;
    logic mask_write;

    logic remote_zero;
    logic remote_span;
    logic zero_active;
    logic span_active;
    logic hold_active;
    logic warning_any;
    logic setup_phase;
    logic access_phase;
    register_select_type select_now;

    generate
        if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : addr_check
            $error("APB address width must lie between 12 and 32.");
        end
        if (SPARE_INPUTS < 1) begin : spare_check
            $error("At least one spare input port is needed.");
        end
    endgenerate

    // ****************************************************************
    // Decoding
    // ****************************************************************
    function automatic register_select_type decode(input logic [ADDR_WIDTH-1:0] address);
        logic [11:0] offset;
        offset = address[11:0];
        if (address[ADDR_WIDTH-1:2] != (ADDR_WIDTH-2)'(offset[11:2])) begin
            decode = SELECT_NONE;
        end else if (offset == `CONDITION_OFFSET) begin
            decode = SELECT_CONDITION;
        end else if (offset == `PIN_STATE_OFFSET) begin
            decode = SELECT_PIN_STATE;
        end else if (offset == `EVENT_OFFSET) begin
            decode = SELECT_EVENT;
        end else if (offset == `EVENT_MASK_OFFSET) begin
            decode = SELECT_EVENT_MASK;
        end else begin
            decode = SELECT_NONE;
        end
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] strobes);
        logic [31:0] mask_bits;
        mask_bits = '0;
        for (int lane = 0; lane < 4; lane++) begin
            mask_bits[lane*8 +: 8] = {8{strobes[lane]}};
        end
        lane_mask = mask_bits;
    endfunction

    // ****************************************************************
    // Pin synchronisers and event flags
    // ****************************************************************
    // Spare inputs are deliberately left unread.
    input_sync #(
        .WIDTH(`REMOTE_COUNT)
    ) remote_sync (
        .clock(clock),
        .resetn(resetn),
        .pin({remote_span_in, remote_zero_in}),
        .level(remote_level)
    );

    event_flags #(
        .WIDTH(`EVENT_COUNT)
    ) events (
        .clock(clock),
        .resetn(resetn),
        .set(event_set),
        .clear(event_clear),
        .mask_write(mask_write),
        .mask_data(pwdata[`EVENT_COUNT-1:0]),
        .flags(event_flags_now),
        .mask(event_mask_now),
        .interrupt(interrupt)
    );

    // ****************************************************************
    // Bus phases
    // ****************************************************************
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign select_now = decode(paddr);
    assign mask_write = access_phase && pwrite && (select_now == SELECT_EVENT_MASK) && pstrb[0];
    assign event_clear = (access_phase && pwrite && (select_now == SELECT_EVENT) && pstrb[0])
        ? pwdata[`EVENT_COUNT-1:0] : `EVENT_RESET;

    // ****************************************************************
    // Operating conditions
    // ****************************************************************
    // Remote zero has priority when the controller drives both inputs.
    assign remote_zero = remote_level[0]; // [RULE6]
    assign remote_span = remote_level[1] && !remote_level[0]; // [RULE7]
    assign zero_active = state.condition.zero_cal_run || remote_zero; // [RULE4] [RULE6]
    assign span_active = state.condition.span_cal_run || remote_span; // [RULE4] [RULE7]
    assign hold_active = state.condition.hold_off || zero_active || span_active;
    assign warning_any = state.condition.warning_active || conc_warning_latched;

    // The front-panel warning holds until software writes a one to its event bit.
    assign conc_warning_latched = event_flags_now[2] || event_flags_now[3]; // [RULE13]

    always_comb begin
        event_set = '0;
        event_set.remote_zero_rise = remote_zero && !state.remote_zero_last;
        event_set.remote_span_rise = remote_span && !state.remote_span_last;
        event_set.conc1_rise = state.condition.conc1_above && !state.conc1_last; // [RULE13]
        event_set.conc2_rise = state.condition.conc2_above && !state.conc2_last; // [RULE13]
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0] write_mask;
        logic [`CONDITION_WIDTH-1:0] merged;
        write_mask = lane_mask(pstrb);
        merged = state.condition;
        next_state = state;

        // Condition register write, honouring byte strobes.
        if (access_phase && pwrite && select_now == SELECT_CONDITION) begin
            merged = (state.condition & ~write_mask[`CONDITION_WIDTH-1:0])
                | (pwdata[`CONDITION_WIDTH-1:0] & write_mask[`CONDITION_WIDTH-1:0]);
            next_state.condition = condition_type'(merged);
        end

        // Read data and error are prepared in the setup cycle and shown in the access cycle.
        if (setup_phase) begin
            next_state.slave_error = (select_now == SELECT_NONE);
            unique case (select_now)
                SELECT_CONDITION: begin
                    next_state.read_data = {{(32 - `CONDITION_WIDTH){1'b0}}, state.condition};
                end
                SELECT_PIN_STATE: begin
                    next_state.read_data = {16'h0000, state.span_indication, state.zero_indication,
                        remote_level, state.relays, state.pins};
                end
                SELECT_EVENT: begin
                    next_state.read_data = {{(32 - `EVENT_COUNT){1'b0}}, event_flags_now};
                end
                SELECT_EVENT_MASK: begin
                    next_state.read_data = {{(32 - `EVENT_COUNT){1'b0}}, event_mask_now};
                end
                SELECT_NONE: begin
                    next_state.read_data = `READ_IDLE;
                end
            endcase
        end

        // Status connector.
        next_state.pins.system_ok = !state.condition.fault_present; // [RULE1]
        next_state.pins.conc_valid = !hold_active && !state.condition.flow_fault
            && !state.condition.fault_present; // [RULE2]
        next_state.pins.high_range = state.condition.in_high_range
            && (state.condition.range_mode == RANGE_DUAL || state.condition.range_mode == RANGE_AUTO); // [RULE3]
        next_state.pins.zero_cal = zero_active; // [RULE4]
        next_state.pins.span_cal = span_active; // [RULE4]
        next_state.pins.service_mode_active = state.condition.diag; // [RULE5]
        next_state.pins.spare_7 = 1'b0; // [RULE15]
        next_state.pins.spare_8 = 1'b0; // [RULE15]

        // Display mode indications.
        next_state.zero_indication = remote_zero; // [RULE6]
        next_state.span_indication = remote_span; // [RULE7]

        // Relay coils; a one energizes the coil, so an unpowered unit reads as a fault.
        next_state.relays.health_relay = !state.condition.fault_present && !warning_any
            && !state.condition.diag; // [RULE8] [RULE9] [RULE10] [RULE11]
        next_state.relays.conc1_relay = state.condition.conc1_above; // [RULE8] [RULE12]
        next_state.relays.conc2_relay = state.condition.conc2_above; // [RULE8]
        next_state.relays.range_relay = state.condition.in_high_range
            && state.condition.range_mode == RANGE_AUTO; // [RULE8] [RULE14]

        // Edge history for the event flags.
        next_state.remote_zero_last = remote_zero;
        next_state.remote_span_last = remote_span;
        next_state.conc1_last = state.condition.conc1_above;
        next_state.conc2_last = state.condition.conc2_above;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state.condition <= condition_type'(`CONDITION_RESET);
            state.read_data <= `READ_IDLE;
            state.slave_error <= 1'b0;
            state.pins <= '0;
            state.relays <= '0;
            state.zero_indication <= 1'b0;
            state.span_indication <= 1'b0;
            state.remote_zero_last <= 1'b0;
            state.remote_span_last <= 1'b0;
            state.conc1_last <= 1'b0;
            state.conc2_last <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The slave never inserts wait states.
    assign pready = 1'b1;
    assign prdata = state.read_data;
    assign pslverr = state.slave_error && access_phase;
    assign status_pins = state.pins;
    assign relays = state.relays;
    assign remote_zero_indication = state.zero_indication;
    assign remote_low_reference_indication = state.span_indication;

endmodule

// ==== dv/status_io_monitor.sv ====
// Concurrent checks on the ports of the analyzer status and control block.
`timescale 1ns/1ps

module status_io_monitor
    import status_io_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int SPARE_INPUTS = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic remote_zero_in,
    input wire logic remote_span_in,
    input wire logic [SPARE_INPUTS-1:0] spare_in,
    input wire status_pins_type status_pins,
    input wire relay_type relays,
    input wire logic remote_zero_indication,
    input wire logic remote_low_reference_indication,
    input wire logic conc_warning_latched,
    input wire logic interrupt
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    spare_pins_a: assert property (!status_pins.spare_7 && !status_pins.spare_8)
        else $error("spare status output driven");
    health_needs_ok_a: assert property (relays.health_relay |-> status_pins.system_ok)
        else $error("health relay energized while a fault is shown");
    diag_drops_health_a: assert property (status_pins.service_mode_active |-> !relays.health_relay)
        else $error("health relay energized in service mode");
    latch_drops_health_a: assert property
        (conc_warning_latched && $past(conc_warning_latched) |-> !relays.health_relay)
        else $error("health relay energized with a latched warning");
    range_relay_a: assert property (relays.range_relay |-> status_pins.high_range)
        else $error("range relay on outside the high range");
    zero_remote_a: assert property
        (remote_zero_in [*4] |-> remote_zero_indication && status_pins.zero_cal)
        else $error("remote zero request not followed");
    zero_release_a: assert property (!remote_zero_in [*4] |-> !remote_zero_indication)
        else $error("remote zero indication without request");
    span_remote_a: assert property
        ((remote_span_in && !remote_zero_in) [*4] |-> remote_low_reference_indication && status_pins.span_cal)
        else $error("remote span request not followed");
    cal_blocks_valid_a: assert property
        (status_pins.zero_cal || status_pins.span_cal |-> !status_pins.conc_valid)
        else $error("reading marked valid during calibration");
    unmapped_error_a: assert property
        (psel && penable && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}) |-> pslverr)
        else $error("unmapped access without error response");
    error_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("error response outside the access phase");
endmodule

bind analyzer_status_control_io status_io_monitor #(.ADDR_WIDTH(ADDR_WIDTH), .SPARE_INPUTS(SPARE_INPUTS)) mon_u (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .remote_zero_in(remote_zero_in), .remote_span_in(remote_span_in), .spare_in(spare_in),
    .status_pins(status_pins), .relays(relays), .remote_zero_indication(remote_zero_indication),
    .remote_low_reference_indication(remote_low_reference_indication),
    .conc_warning_latched(conc_warning_latched), .interrupt(interrupt));

// ==== dv/plc_model.sv ====
// Remote controller that holds the calibration request inputs of the analyzer.
`timescale 1ns/1ps

module plc_model (
    input wire logic clock,
    output logic zero_out,
    output logic span_out
);
    initial begin
        zero_out = 1'b0;
        span_out = 1'b0;
    end

    // A request is a steady level held for as long as the controller wants the mode.
    task automatic drive(input logic zero, input logic span);
        @(posedge clock);
        zero_out <= zero;
        span_out <= span;
    endtask
endmodule

// ==== dv/analyzer_status_control_io_bench.sv ====
// Self-checking testbench of the analyzer status and control block.
`timescale 1ns/1ps
`include "status_io_regs.svh"

module analyzer_status_control_io_bench
    import status_io_pkg::*;
();
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, zero_in, span_in, err;
    logic zero_ind, span_ind, latched, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, spare_in;
    status_pins_type status_pins;
    relay_type relays;
    int fails, check_count;
    logic [11:0] tbl [14] = '{12'h000, 12'h001, 12'h004, 12'h002, 12'h018, 12'h028, 12'h008,
                              12'h038, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400, 12'h800};
    logic [6:0] remote [5] = '{7'b1010100, 7'b0000001, 7'b0101010, 7'b1110100, 7'b0000001};

    analyzer_status_control_io dut_u (
        .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .remote_zero_in(zero_in), .remote_span_in(span_in), .spare_in(spare_in), .status_pins(status_pins),
        .relays(relays), .remote_zero_indication(zero_ind), .remote_low_reference_indication(span_ind),
        .conc_warning_latched(latched), .interrupt(irq));

    plc_model plc_u (.clock(clock), .zero_out(zero_in), .span_out(span_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= 4'hF;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                close_out();
            end
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(name, exp, rd);
    endtask

    // Output pins and relays expected for a condition word with no latched warning.
    function automatic logic [11:0] expect_out(input logic [11:0] c);
        logic hi;
        hi = c[3] && (c[5:4] == 2'h1 || c[5:4] == 2'h2);
        return {c[3] && c[5:4] == 2'h2, c[11], c[10], !(c[0] | c[9] | c[8]),
                2'h0, c[8], c[7], c[6], hi, !(c[0] | c[2] | c[1] | c[6] | c[7]), !c[0]};
    endfunction

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        spare_in = 4'hA;
        resetn = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (12) @(posedge clock);
        check("health relay in reset", 32'h0, relays.health_relay);
        resetn <= 1'b1;
        idle(2);
        check("outputs after reset", 32'h103, {relays, status_pins});
        rchk("condition", `CONDITION_OFFSET, 32'h0);
        check("no error", 32'h0, err);
        rchk("event", `EVENT_OFFSET, 32'h0);
        rchk("event mask", `EVENT_MASK_OFFSET, 32'h0);
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, `CONDITION_OFFSET, {20'h0, tbl[i]});
            idle(3);
            apb(1'b1, `EVENT_OFFSET, 32'h0000_000F);
            idle(2);
            check("pins", expect_out(tbl[i]), {relays, status_pins});
            apb(1'b0, `PIN_STATE_OFFSET, 32'h0);
            check("pin state", expect_out(tbl[i]), rd[11:0]);
            spare_in <= spare_in ^ 4'hF;
        end
        apb(1'b1, `CONDITION_OFFSET, 32'h0000_0400);
        idle(3);
        check("latch relay health irq", 32'hE, {latched, relays.conc1_relay, !relays.health_relay, irq});
        apb(1'b1, `CONDITION_OFFSET, 32'h0000_0000);
        idle(2);
        check("latch after release", 32'h5, {latched, relays.conc1_relay, !relays.health_relay});
        rchk("event latched", `EVENT_OFFSET, 32'h4);
        apb(1'b1, `EVENT_MASK_OFFSET, 32'h0000_0004);
        idle(1);
        check("irq unmasked", 32'h1, irq);
        rchk("event mask", `EVENT_MASK_OFFSET, 32'h4);
        apb(1'b1, `EVENT_OFFSET, 32'h0000_0004);
        idle(2);
        check("latch cleared", 32'h1, {latched, irq, relays.health_relay});
        for (int i = 0; i < 5; i++) begin
            plc_u.drive(remote[i][6], remote[i][5]);
            idle(4);
            check("remote", remote[i][4:0], {zero_ind, span_ind, status_pins.zero_cal,
                                              status_pins.span_cal, status_pins.conc_valid});
        end
        rchk("remote events", `EVENT_OFFSET, 32'h3);
        apb(1'b1, `EVENT_OFFSET, 32'h0000_0003);
        rchk("events cleared", `EVENT_OFFSET, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        check("unmapped write error", 32'h1, err);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped read", 32'h0000_0000, rd);
        check("unmapped read error", 32'h1, err);
        rchk("condition kept", `CONDITION_OFFSET, 32'h0);
        close_out();
    end
endmodule
